// ---- inc/dsp_cfg.svh ----
`ifndef DSP_CFG_SVH
`define DSP_CFG_SVH

// ********************************************************************
// Datapath widths
// ********************************************************************
`define OP_W 18
`define OP9_W 9
`define P18_W 36
`define P9_W 18
`define ACC_GUARD 16
`define ACC_W 52
`define LANE_W 72
`define OUT_W 144
`define N_MULT 4
`define N_PROD9 8
`define N_SET 4
`define N_ACC 2

// ********************************************************************
// Control bundle field positions
// ********************************************************************
`define CTRL_W 6
`define CTL_SA 0
`define CTL_SB 1
`define CTL_AS 2
`define CTL_LD 4

// ********************************************************************
// Reset values and delay selections
// ********************************************************************
`define RST_CTRL 6'h00
`define RST_OVF 2'h0
`define DLY_NONE 2'h0
`define DLY_ONCE 2'h1

`endif

// ---- inc/dsp_pkg.sv ----
// ********************************************************************
// Types shared by the multiply-accumulate datapath
// ********************************************************************
package dsp_pkg;

   // One operating mode per block at a time.
   typedef enum logic [1:0] {
      MODE_SIMPLE,
      MODE_MAC,
      MODE_ADD2,
      MODE_ADD4
   } mode_t;

   // Multiplier arrangement.
   typedef enum logic [1:0] {
      WID_9,
      WID_18,
      WID_36
   } width_t;

endpackage : dsp_pkg

// ---- src/dsp_multiply_accumulate_block.sv ----
`timescale 1ns/100ps
`include "dsp_cfg.svh"

// Overview of operation
// - Eight 9-bit, four 18-bit or one 36-bit multiplier per block.
// - Product is signed if either operand is signed.
// - Sign input high means signed; it covers every multiplier and adder.
// - Adder-stage sign copies take zero to two stages on shared sets.
// - Products keep full precision regardless of signedness.
// - Optional pipeline register after multipliers; pipelines the 36-bit path.
// - Output registers optional everywhere, forced on for accumulation.
// - Adder stage only takes multiplier products, no independent path.
// - First-level adder adds when its select is high, subtracts when low.
// - Two add/subtract selects: one per adder, or per adder pair at 9 bits.
// - Add/subtract selects pass zero, one or two register stages.
// - Accumulator feeds back; sync load replaces it with the product.
// - Registered, non-sticky overflow flag on accumulator over or underflow.
// - Summation totals four products: two units at 9 bits, one at 18.
// - Output mux picks product, adder/accumulator or summation by mode.
// - Output registers use one of four clock, clear and gate sets.
// - Exactly one operating mode per block at any time.
// - Simple mode drives four 18-bit or eight 9-bit products out.
// - 36-bit multiply combines four 18-bit products by shift and add.
// - Up to two 52-bit accumulators fed by second and fourth multipliers.
// - Sync load and overflow only in accumulate mode; subtract for decimation.
// - Two-product mode gives two 18-bit or four 9-bit sums or differences.
// - A and B input registers each select one of four shared sets.

// ********************************************************************
// Configurable multiply, add and accumulate datapath
// ********************************************************************
module dsp_multiply_accumulate_block (
   // Clock and reset
   input wire logic clk,
   input wire logic arst_n,
   // Four shared register sets: clock gate and clear
   input wire logic [`N_SET-1:0] set_en,
   input wire logic [`N_SET-1:0] set_clr,
   // Static configuration
   input dsp_pkg::mode_t mode_sel,
   input dsp_pkg::width_t width_sel,
   input wire logic in_reg_on,
   input wire logic pipe_reg_on,
   input wire logic out_reg_on,
   input wire logic [`N_MULT-1:0][1:0] a_set,
   input wire logic [`N_MULT-1:0][1:0] b_set,
   input wire logic [`N_MULT-1:0][1:0] p_set,
   input wire logic [1:0] ctrl_set,
   input wire logic [1:0] out_set,
   input wire logic [1:0] sign_dly,
   input wire logic [1:0] addsub_dly,
   input wire logic [1:0] sload_dly,
   // Operands
   input wire logic [`N_MULT-1:0][`OP_W-1:0] a_in,
   input wire logic [`N_MULT-1:0][`OP_W-1:0] b_in,
   // Dynamic controls
   input wire logic sign_a,
   input wire logic sign_b,
   input wire logic [1:0] add_or_subtract_sel,
   input wire logic [`N_ACC-1:0] acc_sync_load,
   // Results
   output logic [`OUT_W-1:0] result_q,
   output logic [`N_ACC-1:0] overflow_q
);

   logic [1:0] rst_sync_q;
   logic rst_n;
   logic w9;
   logic w36;
   logic mac;
   logic out_reg_eff;
   logic out_upd;
   logic out_clr_n;
   logic ctrl_clr_n;
   logic [`CTRL_W-1:0] ctrl_raw, ctrl_s1_q, ctrl_s2_q;
   logic [`CTRL_W-1:0] sgn_pick, as_pick, ld_pick;
   logic ms_a, ms_b, ad_a, ad_b;
   logic [1:0] addsub;
   logic [`N_ACC-1:0] sload;
   logic [`N_MULT-1:0][`OP_W-1:0] op_a, op_b;
   logic [`N_MULT-1:0] csa, csb, pf;
   logic [`N_MULT-1:0][`P18_W-1:0] p18;
   logic [`N_PROD9-1:0][`P9_W-1:0] q9;
   logic [`N_MULT-1:0][`LANE_W-1:0] pe18;
   logic [`N_PROD9-1:0][`LANE_W-1:0] pe9;
   logic [1:0][`LANE_W-1:0] s18, sum9;
   logic [3:0][`LANE_W-1:0] t9;
   logic [`LANE_W-1:0] sum18, m36;
   logic [`OUT_W-1:0] simp_w, add2_w, add4_w, mac_w, res_d;
   logic [`N_ACC-1:0][`ACC_W-1:0] acc_q, acc_d;
   logic [`N_ACC-1:0] ovf_d;

   // Pick the undelayed, once or twice registered copy of the controls.
   function automatic logic [`CTRL_W-1:0] dly_pick(
      input logic [1:0] dly,
      input logic [`CTRL_W-1:0] r0,
      input logic [`CTRL_W-1:0] r1,
      input logic [`CTRL_W-1:0] r2);
      dly_pick = (dly == `DLY_NONE) ? r0 : (dly == `DLY_ONCE) ? r1 : r2;
   endfunction : dly_pick

   // ********************************************************************
   // Reset release and mode decode
   // ********************************************************************
   // The reset is released through two flops so all clears leave together.
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
         rst_sync_q <= 2'h0;
      else
         rst_sync_q <= {rst_sync_q[0], 1'b1};
   end

   assign rst_n = rst_sync_q[1];
   assign w9 = (width_sel == dsp_pkg::WID_9);
   assign w36 = (width_sel == dsp_pkg::WID_36);
   // single mode
   // The 36-bit arrangement only multiplies, so it overrides the mode.
   assign mac = (mode_sel == dsp_pkg::MODE_MAC) & ~w36;

   // ********************************************************************
   // Control pipeline for signs, add/subtract and sync load
   // ********************************************************************
   assign ctrl_raw = {acc_sync_load, add_or_subtract_sel, sign_b, sign_a};
   assign ctrl_clr_n = rst_n & ~set_clr[ctrl_set];

   // control stages
   // Both stages share one set so every copy of a control stays in step.
   always_ff @(posedge clk or negedge ctrl_clr_n)
   begin
      if (!ctrl_clr_n)
      begin
         ctrl_s1_q <= `RST_CTRL;
         ctrl_s2_q <= `RST_CTRL;
      end
      else if (set_en[ctrl_set])
      begin
         ctrl_s1_q <= ctrl_raw;
         ctrl_s2_q <= ctrl_s1_q;
      end
   end

   // sign copies
   // Multiplier copy is registered at most once; adder copies up to twice.
   assign ms_a = in_reg_on ? ctrl_s1_q[`CTL_SA] : ctrl_raw[`CTL_SA];
   assign ms_b = in_reg_on ? ctrl_s1_q[`CTL_SB] : ctrl_raw[`CTL_SB];
   assign sgn_pick = dly_pick(sign_dly, ctrl_raw, ctrl_s1_q, ctrl_s2_q);
   assign as_pick = dly_pick(addsub_dly, ctrl_raw, ctrl_s1_q, ctrl_s2_q);
   assign ld_pick = dly_pick(sload_dly, ctrl_raw, ctrl_s1_q, ctrl_s2_q);
   assign ad_a = sgn_pick[`CTL_SA];
   assign ad_b = sgn_pick[`CTL_SB];
   assign addsub = as_pick[`CTL_AS+1:`CTL_AS];
   // load gating
   // Sync load only means something while accumulating.
   assign sload = ld_pick[`CTL_LD+1:`CTL_LD] & {`N_ACC{mac}};

   // ********************************************************************
   // Multiplier cells
   // ********************************************************************
   genvar k;
   generate
      for (k = 0; k < `N_MULT; k = k + 1)
      begin : g_cell
         // wide operand split
         // At 36 bits the cells form low*low, high*low, low*high, high*high.
         assign op_a[k] = w36 ? a_in[k % 2] : a_in[k];
         assign op_b[k] = w36 ? b_in[k / 2] : b_in[k];
         assign csa[k] = ms_a & (~w36 | ((k % 2) == 1));
         assign csb[k] = ms_b & (~w36 | ((k / 2) == 1));
         assign pf[k] = (ad_a & (~w36 | ((k % 2) == 1)))
            | (ad_b & (~w36 | ((k / 2) == 1)));

         mult_cell u_cell (
            .clk(clk),
            .rst_n(rst_n),
            .set_en(set_en),
            .set_clr(set_clr),
            .in_reg_on(in_reg_on),
            .pipe_reg_on(pipe_reg_on),
            .a_set(a_set[k]),
            .b_set(b_set[k]),
            .p_set(p_set[k]),
            .a(op_a[k]),
            .b(op_b[k]),
            .sign_a(csa[k]),
            .sign_b(csb[k]),
            .prod18(p18[k]),
            .prod9_lo(q9[2*k]),
            .prod9_hi(q9[2*k+1])
         );

         // product-only inputs
         // Every adder operand is a product, sign-extended to one lane.
         assign pe18[k] = {{(`LANE_W-`P18_W){pf[k] & p18[k][`P18_W-1]}},
            p18[k]};
         assign pe9[2*k] = {{(`LANE_W-`P9_W){pf[k] & q9[2*k][`P9_W-1]}},
            q9[2*k]};
         assign pe9[2*k+1] = {{(`LANE_W-`P9_W){pf[k] & q9[2*k+1][`P9_W-1]}},
            q9[2*k+1]};
         assign simp_w[36*k +: 36] = w9 ? {q9[2*k+1], q9[2*k]} : p18[k];
         // small adders
         // At 9 bits the upper pair of adders shares the second select.
         assign t9[k] = addsub[k / 2] ? pe9[2*k] + pe9[2*k+1]
            : pe9[2*k] - pe9[2*k+1];
         assign add2_w[36*k +: 36] = t9[k][35:0];
      end

      for (k = 0; k < `N_ACC; k = k + 1)
      begin : g_pair
         logic [`ACC_W:0] base;
         logic [`ACC_W:0] prod_e;
         logic [`ACC_W:0] acc_sum;

         assign s18[k] = addsub[k] ? pe18[2*k] + pe18[2*k+1]
            : pe18[2*k] - pe18[2*k+1];
         assign sum9[k] = t9[2*k] + t9[2*k+1];

         // accumulator input
         // The second and fourth cells feed the two accumulators.
         assign prod_e = w9 ? pe9[4*k+2][`ACC_W:0] : pe18[2*k+1][`ACC_W:0];
         // sync load
         // Loading drops the old total so the sum is just this product.
         assign base = sload[k] ? {(`ACC_W+1){1'b0}}
            : {pf[2*k+1] & acc_q[k][`ACC_W-1], acc_q[k]};
         assign acc_sum = addsub[k] ? base + prod_e : base - prod_e;
         assign acc_d[k] = acc_sum[`ACC_W-1:0];
         // overflow detect
         // Signed totals fail when the guard sign disagrees; unsigned on carry.
         assign ovf_d[k] = mac & (pf[2*k+1]
            ? (acc_sum[`ACC_W] ^ acc_sum[`ACC_W-1]) : acc_sum[`ACC_W]);
         assign mac_w[`LANE_W*k +: `LANE_W] =
            {{(`LANE_W-`ACC_W){pf[2*k+1] & acc_d[k][`ACC_W-1]}}, acc_d[k]};
      end
   endgenerate

   // ********************************************************************
   // Summation, wide multiply and output selection
   // ********************************************************************
   // eighteen-bit summation
   assign sum18 = s18[0] + s18[1];
   assign add4_w = w9 ? {sum9[1], sum9[0]} : {{`LANE_W{1'b0}}, sum18};

   // wide combine
   // Partial products are shifted into place after the pipeline stage.
   assign m36 = pe18[0] + {pe18[1][`LANE_W-`OP_W-1:0], {`OP_W{1'b0}}}
      + {pe18[2][`LANE_W-`OP_W-1:0], {`OP_W{1'b0}}}
      + {pe18[3][`LANE_W-2*`OP_W-1:0], {(2*`OP_W){1'b0}}};

   // output mux
   // The 36-bit arrangement wins; otherwise the block mode and width pick the result.
   always_comb
   begin
      res_d = {`OUT_W{1'b0}};
      if (w36)
         res_d[`LANE_W-1:0] = m36;
      else
      begin
         case (mode_sel)
            dsp_pkg::MODE_SIMPLE: res_d = simp_w;
            dsp_pkg::MODE_MAC: res_d = mac_w;
            dsp_pkg::MODE_ADD2:
               res_d = w9 ? add2_w : {s18[1], s18[0]};
            dsp_pkg::MODE_ADD4: res_d = add4_w;
            default: res_d = {`OUT_W{1'b0}};
         endcase
      end
   end

   // ********************************************************************
   // Output and accumulator registers
   // ********************************************************************
   // forced output register
   // Outputs always come from flops; a bypassed stage loads every cycle.
   assign out_reg_eff = out_reg_on | mac;
   assign out_upd = ~out_reg_eff | set_en[out_set];
   assign out_clr_n = rst_n & ~(out_reg_eff & set_clr[out_set]);

   always_ff @(posedge clk or negedge out_clr_n)
   begin
      if (!out_clr_n)
      begin
         result_q <= {`OUT_W{1'b0}};
         overflow_q <= `RST_OVF;
         acc_q <= {(`N_ACC*`ACC_W){1'b0}};
      end
      else if (out_upd)
      begin
         result_q <= res_d;
         overflow_q <= ovf_d;
         acc_q <= mac ? acc_d : {(`N_ACC*`ACC_W){1'b0}};
      end
   end

endmodule : dsp_multiply_accumulate_block

// ---- src/mult_cell.sv ----
`timescale 1ns/100ps
`include "dsp_cfg.svh"

// ********************************************************************
// One 18x18 multiplier cell, also usable as two 9x9 multipliers
// ********************************************************************
module mult_cell (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Shared register sets
   input wire logic [`N_SET-1:0] set_en,
   input wire logic [`N_SET-1:0] set_clr,
   // Configuration
   input wire logic in_reg_on,
   input wire logic pipe_reg_on,
   input wire logic [1:0] a_set,
   input wire logic [1:0] b_set,
   input wire logic [1:0] p_set,
   // Operands and their signedness
   input wire logic [`OP_W-1:0] a,
   input wire logic [`OP_W-1:0] b,
   input wire logic sign_a,
   input wire logic sign_b,
   // Products
   output logic [`P18_W-1:0] prod18,
   output logic [`P9_W-1:0] prod9_lo,
   output logic [`P9_W-1:0] prod9_hi
);

   logic [`OP_W-1:0] a_q, b_q, a_op, b_op;
   logic a_clr_n, b_clr_n, p_clr_n;
   logic signed [`OP_W:0] a_x, b_x;
   logic signed [`OP9_W:0] al_x, bl_x, ah_x, bh_x;
   logic signed [2*`OP_W+1:0] m18;
   logic signed [2*`OP9_W+1:0] m9lo, m9hi;
   logic [`P18_W+2*`P9_W-1:0] prod_c, prod_q;

   // set clears
   // A set's clear empties its registers at once, without the clock.
   assign a_clr_n = rst_n & ~set_clr[a_set];
   assign b_clr_n = rst_n & ~set_clr[b_set];
   assign p_clr_n = rst_n & ~set_clr[p_set];

   // input register sets
   // The A and B banks each follow their own selected register set.
   always_ff @(posedge clk or negedge a_clr_n)
   begin
      if (!a_clr_n)
         a_q <= {`OP_W{1'b0}};
      else if (set_en[a_set])
         a_q <= a;
   end

   always_ff @(posedge clk or negedge b_clr_n)
   begin
      if (!b_clr_n)
         b_q <= {`OP_W{1'b0}};
      else if (set_en[b_set])
         b_q <= b;
   end

   assign a_op = in_reg_on ? a_q : a;
   assign b_op = in_reg_on ? b_q : b;

   // signed extension
   // One extra bit carries the sign only when the operand is signed.
   assign a_x = {sign_a & a_op[`OP_W-1], a_op};
   assign b_x = {sign_b & b_op[`OP_W-1], b_op};
   assign al_x = {sign_a & a_op[`OP9_W-1], a_op[`OP9_W-1:0]};
   assign bl_x = {sign_b & b_op[`OP9_W-1], b_op[`OP9_W-1:0]};
   assign ah_x = {sign_a & a_op[`OP_W-1], a_op[`OP_W-1:`OP9_W]};
   assign bh_x = {sign_b & b_op[`OP_W-1], b_op[`OP_W-1:`OP9_W]};

   // full precision
   // The top two bits of each wide product only repeat the sign.
   assign m18 = a_x * b_x;
   assign m9lo = al_x * bl_x;
   assign m9hi = ah_x * bh_x;
   assign prod_c = {m9hi[`P9_W-1:0], m9lo[`P9_W-1:0], m18[`P18_W-1:0]};

   // pipeline register
   // Optional stage after the multiplier, on its own register set.
   always_ff @(posedge clk or negedge p_clr_n)
   begin
      if (!p_clr_n)
         prod_q <= {(`P18_W+2*`P9_W){1'b0}};
      else if (set_en[p_set])
         prod_q <= prod_c;
   end

   assign prod18 = pipe_reg_on ? prod_q[`P18_W-1:0] : prod_c[`P18_W-1:0];
   assign prod9_lo = pipe_reg_on ? prod_q[`P18_W+`P9_W-1:`P18_W]
      : prod_c[`P18_W+`P9_W-1:`P18_W];
   assign prod9_hi = pipe_reg_on ? prod_q[`P18_W+2*`P9_W-1:`P18_W+`P9_W]
      : prod_c[`P18_W+2*`P9_W-1:`P18_W+`P9_W];

endmodule : mult_cell

// ---- testbench/dsp_mac_asserts.sv ----
`timescale 1ns/100ps
`include "dsp_cfg.svh"

// ********************************************************************
// Port-level checks for the multiply-accumulate datapath
// ********************************************************************
module dsp_mac_asserts (
   // Clock and reset
   input wire logic clk,
   input wire logic arst_n,
   // Register sets and configuration
   input wire logic [`N_SET-1:0] set_en,
   input wire logic [`N_SET-1:0] set_clr,
   input dsp_pkg::mode_t mode_sel,
   input dsp_pkg::width_t width_sel,
   input wire logic in_reg_on,
   input wire logic pipe_reg_on,
   input wire logic out_reg_on,
   input wire logic [1:0] out_set,
   input wire logic [1:0] sign_dly,
   input wire logic [1:0] addsub_dly,
   input wire logic [1:0] sload_dly,
   // Operands and dynamic controls
   input wire logic [`N_MULT-1:0][`OP_W-1:0] a_in,
   input wire logic [`N_MULT-1:0][`OP_W-1:0] b_in,
   input wire logic sign_a,
   input wire logic sign_b,
   input wire logic [1:0] add_or_subtract_sel,
   input wire logic [`N_ACC-1:0] acc_sync_load,
   // Results
   input wire logic [`OUT_W-1:0] result_q,
   input wire logic [`N_ACC-1:0] overflow_q
);
   logic [1:0] up_q;
   logic [3:0][71:0] p;

   function automatic logic signed [36:0] x18(logic [17:0] v, logic s);
      x18 = {{19{s & v[17]}}, v};
   endfunction : x18

   function automatic logic signed [36:0] x9(logic [8:0] v, logic s);
      x9 = {{28{s & v[8]}}, v};
   endfunction : x9

   function automatic logic [71:0] mul(logic signed [36:0] a, b);
      mul = a * b;
   endfunction : mul

   // Predict results only three edges after release.
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
         up_q <= 2'h0;
      else if (up_q != 2'h3)
         up_q <= up_q + 2'h1;
   end

   // Reference products of the four cells.
   always_comb
   begin
      for (int k = 0; k < 4; k++)
         p[k] = mul(x18(a_in[k], sign_a), x18(b_in[k], sign_b));
   end

   // Reference lanes, wide product, accumulator step and qualifiers.
   wire [71:0] q1 = mul(x9(a_in[0][17:9], sign_a), x9(b_in[0][17:9], sign_b));
   wire [71:0] w36 = mul({sign_a & a_in[1][17], a_in[1], a_in[0]},
                         {sign_b & b_in[1][17], b_in[1], b_in[0]});
   wire [71:0] l0 = add_or_subtract_sel[0] ? p[0] + p[1] : p[0] - p[1];
   wire [71:0] l1 = add_or_subtract_sel[1] ? p[2] + p[3] : p[2] - p[3];
   wire [51:0] step = add_or_subtract_sel[0] ?
      result_q[51:0] + p[1][51:0] : result_q[51:0] - p[1][51:0];
   wire md_s = mode_sel == dsp_pkg::MODE_SIMPLE;
   wire md_m = mode_sel == dsp_pkg::MODE_MAC;
   wire out_on = out_reg_on || md_m;
   wire fast = up_q == 2'h3 && !in_reg_on && !pipe_reg_on && out_on &&
      set_en[out_set] && set_clr == 4'h0 && sign_dly == 2'h0 &&
      addsub_dly == 2'h0 && sload_dly == 2'h0;
   wire w18 = fast && width_sel == dsp_pkg::WID_18;
   wire w9 = fast && width_sel == dsp_pkg::WID_9;

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!arst_n);

   simple18_a: assert property (
      w18 && md_s |=> result_q[143:108] == $past(p[3][35:0]))
      else $error("simple 18-bit lane 3 wrong");
   simple9_a: assert property (
      w9 && md_s |=> result_q[35:18] == $past(q1[17:0]))
      else $error("simple 9-bit product 1 wrong");
   add_pair_a: assert property (
      w18 && mode_sel == dsp_pkg::MODE_ADD2 |=>
      result_q == {$past(l1), $past(l0)})
      else $error("two-product sums wrong");
   add_four_a: assert property (
      w18 && mode_sel == dsp_pkg::MODE_ADD4 |=>
      result_q == {72'h0, $past(l0 + l1)})
      else $error("four-product sum wrong");
   wide_mult_a: assert property (
      fast && width_sel == dsp_pkg::WID_36 |=> result_q == {72'h0, $past(w36)})
      else $error("wide product wrong");
   acc_load_a: assert property (
      w18 && md_m && acc_sync_load[0] && add_or_subtract_sel[0] |=>
      result_q[71:0] == $past(p[1]))
      else $error("accumulator load wrong");
   acc_step_a: assert property (
      w18 && md_m && !acc_sync_load[0] |=> result_q[51:0] == $past(step))
      else $error("accumulator step wrong");
   ovf_mode_a: assert property (
      fast && !md_m |=> overflow_q == 2'h0)
      else $error("overflow outside accumulate mode");
   set_clear_a: assert property (
      set_clr[out_set] && out_on |-> result_q == '0 && overflow_q == 2'h0)
      else $error("output not cleared by its set");
   gate_hold_a: assert property (
      up_q == 2'h3 && out_on && !set_en[out_set] && set_clr == 4'h0
      ##1 set_clr == 4'h0 |-> $stable(result_q))
      else $error("output moved while gated");
endmodule : dsp_mac_asserts

// ---- testbench/dsp_multiply_accumulate_block_tb.sv ----
`timescale 1ns/100ps
`include "dsp_cfg.svh"

// ********************************************************************
// Self-checking bench for the multiply-accumulate datapath
// ********************************************************************
module dsp_multiply_accumulate_block_tb;
   typedef struct {
      dsp_pkg::mode_t m;
      dsp_pkg::width_t w;
      logic sa, sb;
      logic [1:0] sel;
      logic [17:0] a, b;
      logic [143:0] want;
   } row_t;

   logic clk, arst_n, in_reg_on, pipe_reg_on, out_reg_on, sign_a, sign_b;
   logic [3:0] set_en, set_clr;
   dsp_pkg::mode_t mode_sel;
   dsp_pkg::width_t width_sel;
   logic [`N_MULT-1:0][1:0] a_set, b_set, p_set;
   logic [1:0] ctrl_set, out_set, sign_dly, addsub_dly, sload_dly;
   logic [1:0] add_or_subtract_sel, acc_sync_load, overflow_q;
   logic [17:0] base_a, base_b;
   logic [`N_MULT-1:0][`OP_W-1:0] a_in, b_in;
   logic [143:0] result_q;
   int n_mismatch, checked;

   // Plain cases: lane k of A is base plus k, all lanes share B.
   row_t rows [8] = '{
      '{dsp_pkg::MODE_SIMPLE, dsp_pkg::WID_18, 1'b0, 1'b0, 2'h3, 18'h2,
        18'h3, 144'h00000000f_00000000c_000000009_000000006},
      '{dsp_pkg::MODE_SIMPLE, dsp_pkg::WID_18, 1'b1, 1'b0, 2'h3, 18'h3ffff,
        18'h3, 144'h000000006_000000003_000000000_ffffffffd},
      '{dsp_pkg::MODE_SIMPLE, dsp_pkg::WID_18, 1'b0, 1'b0, 2'h3, 18'h3ffff,
        18'h3, 144'h000000006_000000003_000000000_0000bfffd},
      '{dsp_pkg::MODE_SIMPLE, dsp_pkg::WID_9, 1'b0, 1'b0, 2'h3, 18'h00401,
        18'h00605, {18'd6, 18'd20, 18'd6, 18'd15, 18'd6, 18'd10, 18'd6, 18'd5}},
      '{dsp_pkg::MODE_ADD2, dsp_pkg::WID_18, 1'b0, 1'b1, 2'h2, 18'h2,
        18'h3fffd, 144'hffffffffffffffffe5_000000000000000003},
      '{dsp_pkg::MODE_ADD4, dsp_pkg::WID_18, 1'b0, 1'b0, 2'h1, 18'h2,
        18'h3, 144'hc},
      '{dsp_pkg::MODE_ADD2, dsp_pkg::WID_9, 1'b0, 1'b1, 2'h1, 18'h00401,
        18'h007fb, 144'hfffffffe6_fffffffeb_ffffffffc_000000001},
      '{dsp_pkg::MODE_SIMPLE, dsp_pkg::WID_36, 1'b0, 1'b0, 2'h3, 18'h2,
        18'h3, 144'h90003c0006}};

   // Accumulate steps: load, select, halves and overflow.
   logic [1:0] m_ld [4] = '{2'h3, 2'h0, 2'h0, 2'h2};
   logic [1:0] m_sel [4] = '{2'h3, 2'h1, 2'h1, 2'h3};
   logic [71:0] m_h0 [4] = '{72'd9, 72'd18, 72'd27, 72'd36};
   logic [51:0] m_h1 [4] = '{52'd15, 52'd0, 52'hffffffffffff1, 52'd15};
   logic [1:0] m_ov [4] = '{2'h0, 2'h0, 2'h2, 2'h0};

   operand_fabric u_fab (.base_a(base_a), .base_b(base_b), .a_in(a_in),
                         .b_in(b_in));

   dsp_multiply_accumulate_block u_dut (.clk, .arst_n, .set_en, .set_clr,
      .mode_sel, .width_sel, .in_reg_on, .pipe_reg_on, .out_reg_on, .a_set,
      .b_set, .p_set, .ctrl_set, .out_set, .sign_dly, .addsub_dly,
      .sload_dly, .a_in, .b_in, .sign_a, .sign_b, .add_or_subtract_sel,
      .acc_sync_load, .result_q, .overflow_q);

   task automatic chk(input string what, input logic [143:0] want, got);
      checked++;
      if (got !== want)
      begin
         n_mismatch++;
         $display("FAIL %s expected %h seen %h", what, want, got);
      end
   endtask : chk

   task end_of_test;
      $display("comparisons %0d mismatches %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : end_of_test

   // Free-running 200 MHz clock.
   initial
   begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   // The whole run is under fifty cycles; a hang is cut at a thousand.
   initial
   begin
      #5000;
      n_mismatch++;
      $display("watchdog expired");
      end_of_test();
   end

   // Main sequence: reset, table, then the awkward cases by hand.
   initial
   begin
      n_mismatch = 0;
      checked = 0;
      arst_n = 1'b0;
      {set_en, set_clr} = 8'hf0;
      mode_sel = dsp_pkg::MODE_SIMPLE;
      width_sel = dsp_pkg::WID_18;
      {in_reg_on, pipe_reg_on, out_reg_on} = 3'h1;
      {a_set, b_set, p_set} = 24'h0;
      {ctrl_set, out_set, sign_dly, addsub_dly, sload_dly} = 10'h0;
      {sign_a, sign_b, add_or_subtract_sel, acc_sync_load} = 6'hc;
      {base_a, base_b} = 36'h0;
      repeat (3) @(posedge clk);
      #1 arst_n = 1'b1;
      repeat (3) @(posedge clk);
      #1 chk("reset result", 144'h0, result_q);
      chk("reset overflow", 144'h0, 144'(overflow_q));
      $display("test reset done");
      foreach (rows[i])
      begin
         mode_sel = rows[i].m;
         width_sel = rows[i].w;
         {sign_a, sign_b, add_or_subtract_sel} =
            {rows[i].sa, rows[i].sb, rows[i].sel};
         {base_a, base_b} = {rows[i].a, rows[i].b};
         @(posedge clk);
         #1 chk($sformatf("row %0d", i), rows[i].want, result_q);
      end
      $display("test table done");
      {mode_sel, width_sel} = {dsp_pkg::MODE_SIMPLE, dsp_pkg::WID_18};
      {sign_a, sign_b, base_a, base_b} = 38'h0;
      {in_reg_on, pipe_reg_on} = 2'h3;
      {a_set, b_set, p_set, ctrl_set} = 26'h2abfd56;
      {sign_dly, addsub_dly, sload_dly} = 6'h29;
      repeat (3) @(posedge clk);
      #1 base_b = 18'h3;
      for (int i = 1; i < 5; i++)
      begin
         @(posedge clk);
         #1 base_b = 18'h0;
         chk("pipeline", i == 3 ? 144'h9_000000006_000000003_000000000 :
             144'h0, result_q);
      end
      $display("test pipeline done");
      {in_reg_on, pipe_reg_on, sign_dly, addsub_dly, sload_dly} = 8'h0;
      {out_set, base_a, base_b} = {2'h1, 18'h2, 18'h3};
      @(posedge clk);
      #1 set_en = 4'hd;
      base_b = 18'h5;
      repeat (2) @(posedge clk);
      #1 set_clr = 4'h1;
      #1 chk("gated hold", rows[0].want, result_q);
      set_clr = 4'h2;
      #1 chk("set clear", 144'h0, result_q);
      @(posedge clk);
      #1 {set_clr, set_en} = 8'h0f;
      @(posedge clk);
      #1 chk("regated", 144'h19_000000014_00000000f_00000000a,
             result_q);
      $display("test gating done");
      {mode_sel, out_reg_on, base_b} = {dsp_pkg::MODE_MAC, 1'b0, 18'h3};
      for (int i = 0; i < 4; i++)
      begin
         {acc_sync_load, add_or_subtract_sel} = {m_ld[i], m_sel[i]};
         @(posedge clk);
         #1 chk("acc half 0", 144'(m_h0[i]), 144'(result_q[71:0]));
         chk("acc half 1", 144'(m_h1[i]), 144'(result_q[123:72]));
         chk("overflow", 144'(m_ov[i]), 144'(overflow_q));
      end
      $display("test accumulate done");
      end_of_test();
   end
endmodule : dsp_multiply_accumulate_block_tb

bind dsp_multiply_accumulate_block dsp_mac_asserts u_chk (.clk, .arst_n,
   .set_en, .set_clr, .mode_sel, .width_sel, .in_reg_on, .pipe_reg_on,
   .out_reg_on, .out_set, .sign_dly, .addsub_dly, .sload_dly, .a_in, .b_in,
   .sign_a, .sign_b, .add_or_subtract_sel, .acc_sync_load, .result_q,
   .overflow_q);

// ---- testbench/operand_fabric.sv ----
`timescale 1ns/100ps
`include "dsp_cfg.svh"

// ********************************************************************
// Fabric side: operand words for the four multiplier cells
// ********************************************************************
module operand_fabric (
   // Base operand values from the bench
   input wire logic [`OP_W-1:0] base_a,
   input wire logic [`OP_W-1:0] base_b,
   // Operand words towards the block
   output logic [`N_MULT-1:0][`OP_W-1:0] a_in,
   output logic [`N_MULT-1:0][`OP_W-1:0] b_in
);
   // A differs per cell so a swapped lane shows; it wraps in 18 bits.
   always_comb
   begin
      for (int k = 0; k < `N_MULT; k++)
      begin
         a_in[k] = base_a + `OP_W'(k);
         b_in[k] = base_b;
      end
   end
endmodule : operand_fabric
